// ### core/gii_top.sv
// gii_top: instrument-side bus addressing, commands and handshakes
// assumes bus lines as asserted-true bits, synchronous to clk_sys_in;
// an output pair out/oe drives the wire low only while oe is high
`timescale 1ns/1ps
module gii_top #(
    parameter int TX_DEPTH = gii_pkg::TX_DEPTH
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [4:0] addr_in,
    input wire logic talk_only_in,
    input wire logic atn_in,
    input wire logic ifc_in,
    input wire logic ren_in,
    input wire logic [7:0] dio_in,
    output logic [7:0] dio_out,
    output logic dio_oe_out,
    input wire logic eoi_in,
    output logic eoi_out,
    output logic eoi_oe_out,
    input wire logic dav_in,
    output logic dav_out,
    output logic dav_oe_out,
    input wire logic nrfd_in,
    output logic nrfd_out,
    output logic nrfd_oe_out,
    input wire logic ndac_in,
    output logic ndac_out,
    output logic ndac_oe_out,
    output logic srq_out,
    output logic srq_oe_out,
    output logic [7:0] rx_data_out,
    output logic rx_end_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_end_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    input wire logic [7:0] status_in,
    input wire logic rsv_in,
    output logic listen_out,
    output logic talk_out,
    output logic spoll_out,
    output logic remote_out,
    output logic lockout_out,
    output logic dev_clear_out,
    output logic trigger_out
);
    // ==========================================================
    // acceptor state
    typedef enum logic [1:0] {
        AH_IDLE = 2'b00,
        AH_READY = 2'b01,
        AH_ACCEPT = 2'b10
    } gii_ah_t;
    gii_ah_t ah_reg;
    gii_ah_t ah_next;

    logic lad_reg;
    logic tad_reg;
    logic spoll_reg;
    logic polled_reg;
    logic [6:0] cmd;
    logic [6:0] mla;
    logic [6:0] mta;
    logic engaged;
    logic cmd_stb;
    logic data_stb;
    logic talk_act;
    logic [7:0] sb;
    logic [7:0] src_data;
    logic src_last;
    logic src_valid;
    logic src_take;
    logic src_eoi;
    logic [8:0] fifo_data;
    logic fifo_valid;
    logic sb_sent;

    // ==========================================================
    // own addresses
    function automatic logic [6:0] own(input logic [6:0] base,
                                       input logic [4:0] a);
        own = base | {2'b00, a};
    endfunction

    assign mla = own(gii_pkg::LAG_BASE, addr_in);
    assign mta = own(gii_pkg::TAG_BASE, addr_in);
    // the eighth data line is not part of any command
    assign cmd = dio_in[6:0];

    // ==========================================================
    // acceptor handshake
    // commands are taken unless ifc is asserted; data only while listen addressed
    assign engaged = !ifc_in && (atn_in || lad_reg);
    assign cmd_stb = ah_reg == AH_READY && dav_in && atn_in;
    assign data_stb = ah_reg == AH_READY && dav_in && !atn_in
                      && lad_reg;

    always_comb begin
        ah_next = ah_reg;
        case (ah_reg)
            AH_IDLE: begin
                // a full receive slot holds nrfd asserted for data bytes; commands still pass
                if (engaged && !dav_in && (atn_in || !rx_valid_out)) begin
                    ah_next = AH_READY;
                end
            end
            AH_READY: begin
                if (!engaged) begin
                    ah_next = AH_IDLE;
                end else if (dav_in) begin
                    ah_next = AH_ACCEPT;
                end
            end
            AH_ACCEPT: begin
                if (!dav_in || !engaged) begin
                    ah_next = AH_IDLE;
                end
            end
            default: begin
                ah_next = AH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ah_reg <= AH_IDLE;
            nrfd_out <= 1'b0;
            ndac_out <= 1'b0;
        end else begin
            ah_reg <= ah_next;
            nrfd_out <= engaged && ah_next != AH_READY;
            ndac_out <= engaged && ah_next != AH_ACCEPT;
        end
    end
    assign nrfd_oe_out = nrfd_out;
    assign ndac_oe_out = ndac_out;

    // ==========================================================
    // received data
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || dev_clear_out) begin
            rx_valid_out <= 1'b0;
            rx_data_out <= 8'h00;
            rx_end_out <= 1'b0;
        end else if (data_stb) begin
            rx_valid_out <= 1'b1;
            rx_data_out <= dio_in;
            rx_end_out <= eoi_in;
        end else if (rx_ready_in) begin
            rx_valid_out <= 1'b0;
        end
    end

    // ==========================================================
    // addressing; secondary, parallel poll and take control bytes
    // fall through every compare and are ignored
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || ifc_in) begin
            lad_reg <= 1'b0;
        end else if (cmd_stb) begin
            if (cmd == mla) begin
                lad_reg <= 1'b1;
            end else if (cmd == gii_pkg::CMD_UNL || cmd == mta) begin
                lad_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in || ifc_in) begin
            tad_reg <= 1'b0;
        end else if (cmd_stb) begin
            if (cmd == mta) begin
                tad_reg <= 1'b1;
            end else if (cmd == mla) begin
                tad_reg <= 1'b0;
            end else if (cmd[6:5] == gii_pkg::TAG_GRP) begin
                // untalk or another talker's address
                tad_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in || ifc_in) begin
            spoll_reg <= 1'b0;
        end else if (cmd_stb && cmd == gii_pkg::CMD_SPE) begin
            spoll_reg <= 1'b1;
        end else if (cmd_stb && cmd == gii_pkg::CMD_SPD) begin
            spoll_reg <= 1'b0;
        end
    end

    // ==========================================================
    // remote and local
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || !ren_in) begin
            remote_out <= 1'b0;
            lockout_out <= 1'b0;
        end else if (cmd_stb) begin
            if (cmd == mla) begin
                remote_out <= 1'b1;
            end else if (cmd == gii_pkg::CMD_GTL && lad_reg) begin
                remote_out <= 1'b0;
            end
            if (cmd == gii_pkg::CMD_LLO) begin
                lockout_out <= 1'b1;
            end
        end
    end

    // ==========================================================
    // clear and trigger pulses
    // a controller that skips the listen address gets no trigger or selective clear
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            dev_clear_out <= 1'b0;
            trigger_out <= 1'b0;
        end else begin
            dev_clear_out <= cmd_stb && (cmd == gii_pkg::CMD_DCL
                || (cmd == gii_pkg::CMD_SDC && lad_reg));
            trigger_out <= cmd_stb && cmd == gii_pkg::CMD_GET
                && lad_reg;
        end
    end

    // ==========================================================
    // service request and serial poll
    assign sb = {status_in[7], srq_out, status_in[5:0]};
    assign sb_sent = src_take && spoll_reg && src_data[gii_pkg::RQS_BIT];

    always_ff @(posedge clk_sys_in) begin
        if (rst_in || dev_clear_out || !rsv_in) begin
            polled_reg <= 1'b0;
            srq_out <= 1'b0;
        end else begin
            // request drops once the poll has reported it
            polled_reg <= polled_reg || sb_sent;
            srq_out <= !(polled_reg || sb_sent);
        end
    end
    assign srq_oe_out = srq_out;

    // ==========================================================
    // talker path; controller lines are inputs only
    assign talk_act = (tad_reg || talk_only_in) && !atn_in
                      && !ifc_in;
    assign src_data = spoll_reg ? sb : fifo_data[7:0];
    assign src_last = !spoll_reg && fifo_data[8];
    assign src_valid = spoll_reg || fifo_valid;

    gii_fifo #(
        .WIDTH(gii_pkg::TX_WIDTH),
        .DEPTH(TX_DEPTH)
    ) u_tx_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .flush_in(dev_clear_out),
        .in_data_in({tx_end_in, tx_data_in}),
        .in_valid_in(tx_valid_in),
        .in_ready_out(tx_ready_out),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(src_take && !spoll_reg)
    );

    gii_src_hs #(
        .SETTLE(gii_pkg::SETTLE_CYC)
    ) u_src (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .enable_in(talk_act),
        .data_in(src_data),
        .last_in(src_last),
        .valid_in(src_valid),
        .take_out(src_take),
        .nrfd_in(nrfd_in),
        .ndac_in(ndac_in),
        .dav_out(dav_out),
        .dio_out(dio_out),
        .eoi_out(src_eoi),
        .drive_out(dio_oe_out)
    );
    assign dav_oe_out = dav_out;
    assign eoi_out = src_eoi;
    assign eoi_oe_out = src_eoi;
    assign listen_out = lad_reg;
    assign talk_out = tad_reg;
    assign spoll_out = spoll_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    property p_mla_listens;
        cmd_stb && !ifc_in && cmd == ({2'b01, addr_in}) |=> lad_reg;
    endproperty
    a_mla_listens: assert property (p_mla_listens)
        else $error("own listen address did not address listener");

    property p_mla_untalks;
        cmd_stb && !ifc_in && cmd == mla |=> !tad_reg && remote_out == ren_in;
    endproperty
    a_mla_untalks: assert property (p_mla_untalks)
        else $error("talker kept after own listen address");

    property p_mta_unlistens;
        cmd_stb && !ifc_in && cmd == ({2'b10, addr_in})
            |=> tad_reg && !lad_reg;
    endproperty
    a_mta_unlistens: assert property (p_mta_unlistens)
        else $error("listener kept after own talk address");

    property p_rx_needs_listen;
        $rose(rx_valid_out) |-> $past(lad_reg) && !$past(atn_in);
    endproperty
    a_rx_needs_listen: assert property (p_rx_needs_listen)
        else $error("data taken while not listen addressed");

    property p_drive_needs_talk;
        dio_oe_out |-> $past(tad_reg || talk_only_in);
    endproperty
    a_drive_needs_talk: assert property (p_drive_needs_talk)
        else $error("data lines driven while not a talker");

    property p_get_trigger;
        cmd_stb && cmd == gii_pkg::CMD_GET |=> trigger_out == $past(lad_reg)
            ##1 !trigger_out;
    endproperty
    a_get_trigger: assert property (p_get_trigger)
        else $error("trigger pulse wrong after group execute trigger");

    property p_sdc_clear;
        cmd_stb && cmd == gii_pkg::CMD_SDC && lad_reg
            |=> dev_clear_out ##1 !rx_valid_out;
    endproperty
    a_sdc_clear: assert property (p_sdc_clear)
        else $error("selective clear did not clear the device");

    property p_dav_with_data;
        $rose(dav_out) |-> dio_oe_out && $past(dio_oe_out, 2);
    endproperty
    a_dav_with_data: assert property (p_dav_with_data)
        else $error("dav raised without settled data");

    property p_ready_needs_slot;
        $fell(nrfd_out) && !atn_in |-> !rx_valid_out;
    endproperty
    a_ready_needs_slot: assert property (p_ready_needs_slot)
        else $error("ready for data with a full receive slot");
endmodule // gii_top

// ### core/gii_pkg.sv
// gii_pkg: constants of the instrument-side bus interface
// assumes one 250 MHz clock; bus levels arrive as asserted-true bits
package gii_pkg;
    // ==========================================================
    // timing
    localparam int CLK_MHZ = 250;
    localparam int SETTLE_NS = 100;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    // ==========================================================
    // command bytes, seven bits
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [6:0] CMD_UNL = 7'h3f;
    localparam logic [6:0] CMD_UNT = 7'h5f;
    localparam logic [6:0] LAG_BASE = 7'h20;
    localparam logic [6:0] TAG_BASE = 7'h40;
    localparam logic [1:0] TAG_GRP = 2'h2;
    // ==========================================================
    // status byte and buffer
    localparam int RQS_BIT = 6;
    localparam int TX_WIDTH = 9;
    localparam int TX_DEPTH = 8;
endpackage

// ### core/gii_fifo.sv
// gii_fifo: flip-flop fifo with valid/ready on both sides
// assumes depth of at least two; flush empties it in one cycle
`timescale 1ns/1ps
module gii_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic flush_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_reg[rd_reg];
    always_comb cnt_next = cnt_reg + CW'(push) - CW'(pop);

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data_in;
        end
    end

    // flags are registered so full and empty never glitch
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || flush_in) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            in_ready_out <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            if (push) begin
                wr_reg <= bump(wr_reg);
            end
            if (pop) begin
                rd_reg <= bump(rd_reg);
            end
            cnt_reg <= cnt_next;
            in_ready_out <= cnt_next != CW'(DEPTH);
            out_valid_out <= cnt_next != '0;
        end
    end
endmodule // gii_fifo

// ### core/gii_src_hs.sv
// gii_src_hs: source side of the three-wire byte handshake
// assumes enable drops at once when atn is asserted
`timescale 1ns/1ps
module gii_src_hs #(
    parameter int SETTLE = gii_pkg::SETTLE_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic [7:0] data_in,
    input wire logic last_in,
    input wire logic valid_in,
    output logic take_out,
    input wire logic nrfd_in,
    input wire logic ndac_in,
    output logic dav_out,
    output logic [7:0] dio_out,
    output logic eoi_out,
    output logic drive_out
);
    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_SETTLE = 2'b01,
        SH_VALID = 2'b10
    } gii_sh_t;
    gii_sh_t sh_reg;
    logic [7:0] cnt_reg;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in || !enable_in) begin
            sh_reg <= SH_IDLE;
            cnt_reg <= 8'h00;
            dav_out <= 1'b0;
            drive_out <= 1'b0;
            eoi_out <= 1'b0;
            take_out <= 1'b0;
            dio_out <= 8'h00;
        end else begin
            take_out <= 1'b0;
            case (sh_reg)
                SH_IDLE: begin
                    drive_out <= 1'b1;
                    eoi_out <= 1'b0;
                    // the head pops one edge after take; wait it out so
                    // a fast acceptor never gets the same byte twice
                    if (valid_in && !nrfd_in && !take_out) begin
                        dio_out <= data_in;
                        eoi_out <= last_in;
                        cnt_reg <= 8'(SETTLE);
                        sh_reg <= SH_SETTLE;
                    end
                end
                // data settles on the wires before dav is shown
                SH_SETTLE: begin
                    if (cnt_reg <= 8'h01) begin
                        dav_out <= 1'b1;
                        sh_reg <= SH_VALID;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                SH_VALID: begin
                    if (!ndac_in) begin
                        dav_out <= 1'b0;
                        take_out <= 1'b1;
                        sh_reg <= SH_IDLE;
                    end
                end
                default: begin
                    sh_reg <= SH_IDLE;
                end
            endcase
        end
    end
endmodule // gii_src_hs

// ### verif/gii_ctl_model.sv
// gii_ctl_model: bus controller and peer acceptor for the bench
// assumes asserted-true bus bits; the bench forms the wired-or levels
`timescale 1ns/1ps
module gii_ctl_model (
    input wire logic clk_in,
    input wire logic nrfd_in,
    input wire logic ndac_in,
    input wire logic dav_in,
    input wire logic [7:0] dio_in,
    input wire logic eoi_in,
    output logic atn_out,
    output logic dav_out,
    output logic [7:0] dio_out,
    output logic eoi_out,
    output logic nrfd_out,
    output logic ndac_out,
    output logic hang_out
);
    // idle as a not-ready acceptor so the device never sends unasked
    initial begin
        {atn_out, dav_out, dio_out, eoi_out, hang_out} = '0;
        {nrfd_out, ndac_out} = 2'b11;
    end
    // ==========================================
    // bounded wait for a handshake level
    task automatic waitfor(input int sel, input logic want);
        int n;
        n = 0;
        while ((sel == 0 ? nrfd_in : sel == 1 ? ndac_in : dav_in) !== want)
        begin
            @(negedge clk_in);
            n++;
            if (n > 2000) begin
                hang_out = 1'b1;
                return;
            end
        end
    endtask
    // ==========================================
    // source one byte; atn held afterwards until changed
    task automatic send(input logic atn, input logic [7:0] b,
                        input logic e);
        @(negedge clk_in);
        {nrfd_out, ndac_out} = 2'b00;
        atn_out = atn;
        // let the acceptor see the new atn level before nrfd counts
        @(negedge clk_in);
        waitfor(0, 1'b0);
        dio_out = b;
        eoi_out = e;
        @(negedge clk_in);
        dav_out = 1'b1;
        // dav stands over a rising edge even for a deaf device
        @(negedge clk_in);
        waitfor(1, 1'b0);
        dav_out = 1'b0;
        dio_out = 8'h00;
        eoi_out = 1'b0;
        repeat (2) @(negedge clk_in);
    endtask
    // ==========================================
    // accept one byte from the device; slow stretches acceptance
    task automatic recv(output logic [8:0] got, input int slow);
        @(negedge clk_in);
        atn_out = 1'b0;
        // ndac held until the byte is really taken
        {nrfd_out, ndac_out} = 2'b01;
        waitfor(2, 1'b1);
        nrfd_out = 1'b1;
        got = {eoi_in, dio_in};
        repeat (slow) @(negedge clk_in);
        ndac_out = 1'b0;
        waitfor(2, 1'b0);
        @(negedge clk_in);
        ndac_out = 1'b1;
    endtask
endmodule // gii_ctl_model

// ### verif/gii_top_test.sv
// gii_top_test: self-checking bench of the instrument bus interface
// assumes gii_ctl_model as controller; pull-ups make released lines 0
`timescale 1ns/1ps
module gii_top_test;
    logic clk_sys_in = 0, rst_in = 1, talk_only_in = 0, ifc_in = 0;
    logic ren_in = 1, rx_ready_in = 1, tx_end_in = 0, tx_valid_in = 0;
    logic rsv_in = 0, tb_hang = 0;
    logic [4:0] addr_in = 5'h10;
    logic [7:0] tx_data_in = 8'h00, status_in = 8'h00, dio_out, rx_data_out;
    logic dio_oe_out, eoi_out, eoi_oe_out, dav_out, dav_oe_out, nrfd_out;
    logic nrfd_oe_out, ndac_out, ndac_oe_out, srq_out, srq_oe_out;
    logic rx_end_out, rx_valid_out, tx_ready_out, listen_out, talk_out;
    logic spoll_out, remote_out, lockout_out, dev_clear_out, trigger_out;
    logic atn_in, c_dav, c_eoi, c_nrfd, c_ndac, hang;
    logic [7:0] c_dio;
    wire [7:0] dio_in = c_dio | (dio_oe_out ? dio_out : 8'h00);
    wire eoi_in = c_eoi | (eoi_oe_out & eoi_out);
    wire dav_in = c_dav | (dav_oe_out & dav_out);
    wire nrfd_in = c_nrfd | (nrfd_oe_out & nrfd_out);
    wire ndac_in = c_ndac | (ndac_oe_out & ndac_out);
    int miscompares = 0, check_count = 0, clr_n = 0, trig_n = 0;
    logic [8:0] rx_q[$];
    gii_top dut (.clk_sys_in, .rst_in, .addr_in, .talk_only_in, .atn_in,
        .ifc_in, .ren_in, .dio_in, .dio_out, .dio_oe_out, .eoi_in, .eoi_out,
        .eoi_oe_out, .dav_in, .dav_out, .dav_oe_out, .nrfd_in, .nrfd_out,
        .nrfd_oe_out, .ndac_in, .ndac_out, .ndac_oe_out, .srq_out,
        .srq_oe_out, .rx_data_out, .rx_end_out, .rx_valid_out, .rx_ready_in,
        .tx_data_in, .tx_end_in, .tx_valid_in, .tx_ready_out, .status_in,
        .rsv_in, .listen_out, .talk_out, .spoll_out, .remote_out,
        .lockout_out, .dev_clear_out, .trigger_out);
    gii_ctl_model ctl (.clk_in(clk_sys_in), .nrfd_in, .ndac_in, .dav_in,
        .dio_in, .eoi_in, .atn_out(atn_in), .dav_out(c_dav),
        .dio_out(c_dio), .eoi_out(c_eoi), .nrfd_out(c_nrfd),
        .ndac_out(c_ndac), .hang_out(hang));
    always #2 clk_sys_in = ~clk_sys_in;
    // ==========================================
    // monitors: pulses and received bytes, sampled before the edge lands
    always @(posedge clk_sys_in) begin
        if (dev_clear_out === 1'b1) clr_n++;
        if (trigger_out === 1'b1) trig_n++;
        if (rx_valid_out === 1'b1 && rx_ready_in === 1'b1)
            rx_q.push_back({rx_end_out, rx_data_out});
    end
    always @(posedge hang or posedge tb_hang) begin
        miscompares++;
        results();
    end
    // ==========================================
    // checking and closing
    task automatic check(input string what, input logic [8:0] seen,
                         input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // status byte as a poll returns it: request bit in bit 6, no eoi
    function automatic logic [8:0] poll_byte(input logic [7:0] s);
        return {1'b0, s[7], 1'b1, s[5:0]};
    endfunction
    task automatic results();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] b);
        ctl.send(1'b1, b, 1'b0);
    endtask
    task automatic push(input logic [7:0] d, input logic e);
        int n;
        n = 0;
        @(negedge clk_sys_in);
        tx_data_in = d;
        tx_end_in = e;
        tx_valid_in = 1'b1;
        while (tx_ready_out !== 1'b1) begin
            @(negedge clk_sys_in);
            n++;
            if (n > 500) tb_hang = 1'b1;
        end
        @(negedge clk_sys_in);
        tx_valid_in = 1'b0;
    endtask
    // ==========================================
    // main sequence
    initial begin
        logic [8:0] got;
        logic [7:0] t [8];
        logic [4:0] a;
        void'($urandom(3334));
        repeat (3) @(negedge clk_sys_in);
        rst_in = 1'b0;
        @(negedge clk_sys_in);
        check("idle", {talk_out, dio_oe_out, tx_ready_out}, 9'h1);
        ctl.send(1'b0, 8'h55, 1'b0);
        check("unaddressed rx", 9'(rx_q.size()), 9'h0);
        cmd(8'h08);
        check("unaddressed trigger", 9'(trig_n), 9'h0);
        cmd(8'h3f);
        cmd(8'h30);
        check("listen", {remote_out, listen_out}, 9'h3);
        // common command text travels with atn released
        for (int i = 0; i < 4; i++) begin
            t[i] = 8'($urandom);
            ctl.send(1'b0, t[i], i == 3);
        end
        for (int i = 0; i < 4; i++)
            check("rx byte", rx_q.pop_front(), {i == 3, t[i]});
        cmd(8'h04);
        check("selective clear", 9'(clr_n), 9'h1);
        cmd(8'h08);
        check("trigger", 9'(trig_n), 9'h1);
        cmd(8'h11);
        cmd(8'h01);
        check("local", {lockout_out, remote_out}, 9'h2);
        cmd(8'h05);
        cmd(8'h09);
        cmd(8'h65);
        check("ignored", {listen_out, talk_out, dio_oe_out}, 9'h4);
        // fill the buffer before the talk address, then drain it
        for (int i = 0; i < 8; i++) begin
            t[i] = 8'($urandom);
            push(t[i], i == 7);
        end
        check("tx full", 9'(tx_ready_out), 9'h0);
        cmd(8'h50);
        check("talk", {talk_out, listen_out}, 9'h2);
        for (int i = 0; i < 8; i++) begin
            ctl.recv(got, (i % 2) * 9);
            check("tx byte", got, {i == 7, t[i]});
        end
        @(negedge clk_sys_in);
        check("tx drained", 9'(tx_ready_out), 9'h1);
        cmd(8'h30);
        check("talk dropped", {talk_out, listen_out}, 9'h1);
        status_in = 8'($urandom);
        rsv_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        check("srq", 9'(srq_out), 9'h1);
        cmd(8'h18);
        cmd(8'h50);
        ctl.recv(got, 0);
        check("status", got, poll_byte(status_in));
        cmd(8'h19);
        check("srq served", {spoll_out, srq_out}, 9'h0);
        rsv_in = 1'b0;
        cmd(8'h14);
        check("clear", 9'(clr_n), 9'h2);
        ifc_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        ifc_in = 1'b0;
        check("ifc", {talk_out, listen_out}, 9'h0);
        // talk-only: no address needed to source a byte
        talk_only_in = 1'b1;
        t[0] = 8'($urandom);
        push(t[0], 1'b1);
        ctl.recv(got, 0);
        talk_only_in = 1'b0;
        check("talk only", got, {1'b1, t[0]});
        a = 5'($urandom_range(0, 30));
        addr_in = a;
        cmd({3'b001, a});
        check("listen any", 9'(listen_out), 9'h1);
        cmd({3'b010, a});
        check("talk any", {talk_out, listen_out}, 9'h2);
        ren_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        check("ren off", 9'(remote_out), 9'h0);
        results();
    end
endmodule // gii_top_test
